// file: hdl/tmcu_top.sv
// match, capture and external match unit of a 32-bit timer
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tmcu_cfg.svh"

// Behaviour
// - each match value is compared with the timer count every cycle
// - a match may raise an interrupt, reset the count or stop the timer
// - four 32-bit read/write match values at successive words, reset zero
// - capture loads happen only while the capture enable bit is set
// - with capture interrupt enable, every capture load requests an interrupt
// - falling-edge select: a high then low input loads the timer count
// - rising-edge select: a low then high input loads the timer count
// - both edge selects together capture on every edge
// - enabling capture switches the pin to capture use by hardware
// - capture value is a read-only 32-bit word, reset zero, writes ignored
// - external match register controls and reports the four match pins
// - outputs in pwm mode ignore their match actions; state bit writes still drive the pins
// - output 3 action: none, low, high, toggle on each channel 3 match
// - output 2 uses the same action encoding on each channel 2 match
// - outputs 1 and 0 use the same encoding; state bits drive the pins
// - stop on match raises the count stop request to the timer core, one cycle after the match
module tmcu_top
  import tmcu_pkg::*;
(
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // apb slave
  input  wire tmcu_apb_req_s              apb_req,
  output var  tmcu_apb_rsp_s              apb_rsp,
  // timer core
  input  wire logic [`TMCU_DATA_W-1:0]    timer_count,
  input  wire logic [`TMCU_MATCH_ACTION_CONTROL_W-1:0]   match_action_control,
  input  wire logic [`TMCU_CHANNELS-1:0]  pwm_mode,
  output logic      [`TMCU_CHANNELS-1:0]  match_event,
  output logic                            count_reset_req,
  output logic                            count_stop_req,
  // pins
  input  wire logic                       capture_input_pin,
  output logic                            capture_pin_select,
  output logic      [`TMCU_CHANNELS-1:0]  match_pin,
  // interrupt
  output logic                            irq
);

  // ----------------------------------------
  // functions
  // ----------------------------------------

  // next state of a match output for an action code
  function automatic logic apply_action(
    input logic         state,
    input tmcu_action_t code
  );
    logic res;
    res = state;
    case (code)
      `TMCU_ACT_NONE:   res = state;
      `TMCU_ACT_LOW:    res = 1'b0;
      `TMCU_ACT_HIGH:   res = 1'b1;
      `TMCU_ACT_TOGGLE: res = ~state;
      default:          res = state;
    endcase
    return res;
  endfunction : apply_action

  // one bit of the match action control word
  function automatic logic match_action_control_bit(
    input logic [`TMCU_MATCH_ACTION_CONTROL_W-1:0] word,
    input int                       chan,
    input int                       ofs
  );
    return word[chan*`TMCU_MATCH_ACTION_CONTROL_STRIDE+ofs];
  endfunction : match_action_control_bit

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [`TMCU_DATA_W-1:0]     match_value_ff [`TMCU_CHANNELS];
  logic [`TMCU_CAP_CTRL_W-1:0] capture_control_ff;
  logic [`TMCU_DATA_W-1:0]     capture_value_ff;
  logic [`TMCU_CHANNELS-1:0]   match_out_state_ff;
  tmcu_action_t                match_out_action_ff [`TMCU_CHANNELS];
  logic [`TMCU_IRQ_W-1:0]      irq_status_ff;
  logic [`TMCU_IRQ_W-1:0]      irq_mask_ff;
  logic [`TMCU_CHANNELS-1:0]   equal_prev_ff;
  logic [`TMCU_CHANNELS-1:0]   match_event_ff;
  logic                        count_reset_req_ff;
  logic                        count_stop_req_ff;
  logic [`TMCU_CHANNELS-1:0]   match_pin_ff;
  logic                        capture_pin_select_ff;
  logic                        irq_ff;
  logic                        cap_sync1_ff;
  logic                        cap_sync2_ff;
  logic                        cap_prev_ff;
  tmcu_apb_rsp_s               apb_rsp_ff;

  // ----------------------------------------
  // combinational terms
  // ----------------------------------------
  logic                        bus_access;
  logic                        bus_commit;
  logic                        wr_commit;
  logic                        addr_hit;
  logic [`TMCU_DATA_W-1:0]     rd_data;
  logic [`TMCU_CHANNELS-1:0]   equal_now;
  logic [`TMCU_CHANNELS-1:0]   match_hit;
  logic [`TMCU_CHANNELS-1:0]   match_irq_set;
  logic                        cap_rise;
  logic                        cap_fall;
  logic                        cap_load;
  logic [`TMCU_IRQ_W-1:0]      irq_set;
  logic [`TMCU_CHANNELS-1:0]   nxt_match_out_state;
  logic [`TMCU_IRQ_W-1:0]      nxt_irq_status;
  logic                        any_reset;
  logic                        any_stop;

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------

  // access phase seen, answer one cycle later
  assign bus_access = apb_req.psel & apb_req.penable;
  assign bus_commit = bus_access & apb_rsp_ff.pready;
  assign wr_commit  = bus_commit & apb_req.pwrite & addr_hit;

  // address decode and read mux
  always_comb begin
    addr_hit = 1'b1;
    rd_data  = `TMCU_ZERO32;
    case (apb_req.paddr)
      `TMCU_OFS_MATCH_VALUE_0:   rd_data = match_value_ff[0];
      `TMCU_OFS_MATCH_VALUE_1:   rd_data = match_value_ff[1];
      `TMCU_OFS_MATCH_VALUE_2:   rd_data = match_value_ff[2];
      `TMCU_OFS_MATCH_VALUE_3:   rd_data = match_value_ff[3];
      `TMCU_OFS_CAPTURE_CONTROL: begin
        rd_data[`TMCU_CAP_CTRL_W-1:0] = capture_control_ff;
      end
      `TMCU_OFS_CAPTURE_VALUE:   rd_data = capture_value_ff;
      `TMCU_OFS_EXT_MATCH_CTRL: begin
        rd_data[`TMCU_EM_STATE_LSB +: `TMCU_CHANNELS] = match_out_state_ff;
        for (int i = 0; i < `TMCU_CHANNELS; i++) begin
          rd_data[`TMCU_EM_ACTION_LSB+2*i +: 2] = match_out_action_ff[i];
        end
      end
      `TMCU_OFS_IRQ_STATUS:      rd_data[`TMCU_IRQ_W-1:0] = irq_status_ff;
      `TMCU_OFS_IRQ_MASK:        rd_data[`TMCU_IRQ_W-1:0] = irq_mask_ff;
      default:                   addr_hit = 1'b0;
    endcase
  end

  // answer: one wait state, error on unmapped address
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      apb_rsp_ff <= '0;
    end else if (bus_access & ~apb_rsp_ff.pready) begin
      apb_rsp_ff.pready  <= 1'b1;
      apb_rsp_ff.pslverr <= ~addr_hit;
      apb_rsp_ff.prdata  <= apb_req.pwrite ? `TMCU_ZERO32 : rd_data;
    end else begin
      apb_rsp_ff.pready  <= 1'b0;
      apb_rsp_ff.pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // match values
  // ----------------------------------------

  // software writes of the match words
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `TMCU_CHANNELS; i++) begin
        match_value_ff[i] <= `TMCU_ZERO32;
      end
    end else if (wr_commit) begin
      case (apb_req.paddr)
        `TMCU_OFS_MATCH_VALUE_0: match_value_ff[0] <= apb_req.pwdata;
        `TMCU_OFS_MATCH_VALUE_1: match_value_ff[1] <= apb_req.pwdata;
        `TMCU_OFS_MATCH_VALUE_2: match_value_ff[2] <= apb_req.pwdata;
        `TMCU_OFS_MATCH_VALUE_3: match_value_ff[3] <= apb_req.pwdata;
        default:                 ;
      endcase
    end
  end

  // ----------------------------------------
  // comparison and match actions
  // ----------------------------------------

  // continuous equality; event on entering equality
  always_comb begin
    for (int i = 0; i < `TMCU_CHANNELS; i++) begin
      equal_now[i] = (timer_count == match_value_ff[i]);
    end
  end

  assign match_hit = equal_now & ~equal_prev_ff;

  // per-channel interrupt, reset and stop selections
  always_comb begin
    any_reset = 1'b0;
    any_stop  = 1'b0;
    for (int i = 0; i < `TMCU_CHANNELS; i++) begin
      match_irq_set[i] = match_hit[i] &
                         match_action_control_bit(match_action_control, i, `TMCU_MATCH_ACTION_CONTROL_IE_OFS);
      any_reset = any_reset | (match_hit[i] &
                  match_action_control_bit(match_action_control, i, `TMCU_MATCH_ACTION_CONTROL_RST_OFS));
      any_stop  = any_stop  | (match_hit[i] &
                  match_action_control_bit(match_action_control, i, `TMCU_MATCH_ACTION_CONTROL_STOP_OFS));
    end
  end

  // equality history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      equal_prev_ff <= '0;
    end else begin
      equal_prev_ff <= equal_now;
    end
  end

  // match pulses to the timer core
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      match_event_ff     <= '0;
      count_reset_req_ff <= 1'b0;
      count_stop_req_ff  <= 1'b0;
    end else begin
      match_event_ff     <= match_hit;
      count_reset_req_ff <= any_reset;
      count_stop_req_ff  <= any_stop;
    end
  end

  // ----------------------------------------
  // external match outputs
  // ----------------------------------------

  // software write first, a match outside pwm mode on the same cycle overrides it
  always_comb begin
    nxt_match_out_state = match_out_state_ff;
    if (wr_commit && apb_req.paddr == `TMCU_OFS_EXT_MATCH_CTRL) begin
      nxt_match_out_state = apb_req.pwdata[`TMCU_EM_STATE_LSB +: `TMCU_CHANNELS];
    end
    for (int i = 0; i < `TMCU_CHANNELS; i++) begin
      if (match_hit[i] && !pwm_mode[i]) begin
        nxt_match_out_state[i] = apply_action(match_out_state_ff[i],
                                              match_out_action_ff[i]);
      end
    end
  end

  // state bits and action fields
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      match_out_state_ff <= '0;
      for (int i = 0; i < `TMCU_CHANNELS; i++) begin
        match_out_action_ff[i] <= `TMCU_ACT_NONE;
      end
    end else begin
      match_out_state_ff <= nxt_match_out_state;
      if (wr_commit && apb_req.paddr == `TMCU_OFS_EXT_MATCH_CTRL) begin
        for (int i = 0; i < `TMCU_CHANNELS; i++) begin
          match_out_action_ff[i] <= apb_req.pwdata[`TMCU_EM_ACTION_LSB+2*i +: 2];
        end
      end
    end
  end

  // pins follow the state bits
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      match_pin_ff <= '0;
    end else begin
      match_pin_ff <= nxt_match_out_state;
    end
  end

  // ----------------------------------------
  // capture
  // ----------------------------------------

  // capture control register, reserved bits dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      capture_control_ff <= '0;
    end else if (wr_commit && apb_req.paddr == `TMCU_OFS_CAPTURE_CONTROL) begin
      capture_control_ff <= apb_req.pwdata[`TMCU_CAP_CTRL_W-1:0];
    end
  end

  // pin synchroniser and sample history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cap_sync1_ff <= 1'b0;
      cap_sync2_ff <= 1'b0;
      cap_prev_ff  <= 1'b0;
    end else begin
      cap_sync1_ff <= capture_input_pin;
      cap_sync2_ff <= cap_sync1_ff;
      cap_prev_ff  <= cap_sync2_ff;
    end
  end

  // edges from two consecutive samples
  assign cap_rise = cap_sync2_ff & ~cap_prev_ff;
  assign cap_fall = ~cap_sync2_ff & cap_prev_ff;

  // load condition, either or both edges
  assign cap_load = capture_control_ff[`TMCU_CAP_EN_BIT] &
                    ((cap_rise & capture_control_ff[`TMCU_CAP_RISE_BIT]) |
                     (cap_fall & capture_control_ff[`TMCU_CAP_FALL_BIT]));

  // captured count, never written by software
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      capture_value_ff <= `TMCU_ZERO32;
    end else if (cap_load) begin
      capture_value_ff <= timer_count;
    end
  end

  // pin function switches with the enable bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      capture_pin_select_ff <= 1'b0;
    end else begin
      capture_pin_select_ff <= capture_control_ff[`TMCU_CAP_EN_BIT];
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------

  // events that set sticky status bits
  always_comb begin
    irq_set = '0;
    irq_set[`TMCU_CHANNELS-1:0] = match_irq_set;
    irq_set[`TMCU_IRQ_CAP_BIT]  = cap_load &
                                  capture_control_ff[`TMCU_CAP_IE_BIT];
  end

  // write one to clear, a new event wins
  always_comb begin
    nxt_irq_status = irq_status_ff;
    if (wr_commit && apb_req.paddr == `TMCU_OFS_IRQ_STATUS) begin
      nxt_irq_status = irq_status_ff & ~apb_req.pwdata[`TMCU_IRQ_W-1:0];
    end
    nxt_irq_status = nxt_irq_status | irq_set;
  end

  // status and mask registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status_ff <= '0;
      irq_mask_ff   <= '0;
    end else begin
      irq_status_ff <= nxt_irq_status;
      if (wr_commit && apb_req.paddr == `TMCU_OFS_IRQ_MASK) begin
        irq_mask_ff <= apb_req.pwdata[`TMCU_IRQ_W-1:0];
      end
    end
  end

  // level interrupt line
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_irq_status & irq_mask_ff);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign apb_rsp            = apb_rsp_ff;
  assign match_event        = match_event_ff;
  assign count_reset_req    = count_reset_req_ff;
  assign count_stop_req     = count_stop_req_ff;
  assign capture_pin_select = capture_pin_select_ff;
  assign match_pin          = match_pin_ff;
  assign irq                = irq_ff;

endmodule : tmcu_top

`default_nettype wire

// file: hdl/tmcu_cfg.svh
// register map, field positions, reset values and codes of the match/capture unit
`ifndef TMCU_CFG_SVH
`define TMCU_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TMCU_OFS_MATCH_VALUE_0   12'h018
`define TMCU_OFS_MATCH_VALUE_1   12'h01C
`define TMCU_OFS_MATCH_VALUE_2   12'h020
`define TMCU_OFS_MATCH_VALUE_3   12'h024
`define TMCU_OFS_CAPTURE_CONTROL 12'h028
`define TMCU_OFS_CAPTURE_VALUE   12'h02C
`define TMCU_OFS_EXT_MATCH_CTRL  12'h030
`define TMCU_OFS_IRQ_STATUS      12'h034
`define TMCU_OFS_IRQ_MASK        12'h038

// ----------------------------------------
// capture control fields
// ----------------------------------------
`define TMCU_CAP_RISE_BIT        0
`define TMCU_CAP_FALL_BIT        1
`define TMCU_CAP_IE_BIT          2
`define TMCU_CAP_EN_BIT          3
`define TMCU_CAP_CTRL_W          4

// ----------------------------------------
// external match fields
// ----------------------------------------
`define TMCU_EM_STATE_LSB        0
`define TMCU_EM_ACTION_LSB       4
`define TMCU_EM_W                12

// ----------------------------------------
// match action control fields, per channel
// ----------------------------------------
`define TMCU_MATCH_ACTION_CONTROL_IE_OFS        0
`define TMCU_MATCH_ACTION_CONTROL_RST_OFS       1
`define TMCU_MATCH_ACTION_CONTROL_STOP_OFS      2
`define TMCU_MATCH_ACTION_CONTROL_STRIDE        3
`define TMCU_MATCH_ACTION_CONTROL_W             12

// ----------------------------------------
// interrupt status fields
// ----------------------------------------
`define TMCU_IRQ_CAP_BIT         4
`define TMCU_IRQ_W               5

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define TMCU_CHANNELS            4
`define TMCU_DATA_W              32
`define TMCU_ADDR_W              12
`define TMCU_ZERO32              32'h0000_0000
`define TMCU_ACT_NONE            2'h0
`define TMCU_ACT_LOW             2'h1
`define TMCU_ACT_HIGH            2'h2
`define TMCU_ACT_TOGGLE          2'h3

`endif

// file: hdl/tmcu_pkg.sv
// types shared by the match/capture unit
`default_nettype none
`include "tmcu_cfg.svh"
package tmcu_pkg;

  // apb request from the master
  typedef struct packed {
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [`TMCU_ADDR_W-1:0]   paddr;
    logic [`TMCU_DATA_W-1:0]   pwdata;
  } tmcu_apb_req_s;

  // apb answer to the master
  typedef struct packed {
    logic                      pready;
    logic                      pslverr;
    logic [`TMCU_DATA_W-1:0]   prdata;
  } tmcu_apb_rsp_s;

  // action code of one match output
  typedef logic [1:0] tmcu_action_t;

endpackage : tmcu_pkg

`default_nettype wire

// file: testbench/tmcu_monitor.sv
// port checker of the match/capture unit
`timescale 1ns/1ps
`default_nettype none
`include "tmcu_cfg.svh"
module tmcu_monitor
  import tmcu_pkg::*;
(
  // clock and reset
  input wire logic                      clock,
  input wire logic                      rst,
  // bus and timer core
  input wire tmcu_apb_req_s             apb_req,
  input wire tmcu_apb_rsp_s             apb_rsp,
  input wire logic [`TMCU_MATCH_ACTION_CONTROL_W-1:0]  match_action_control,
  input wire logic [`TMCU_CHANNELS-1:0] pwm_mode,
  input wire logic [`TMCU_CHANNELS-1:0] match_event,
  input wire logic                      count_reset_req,
  input wire logic                      count_stop_req,
  // pins
  input wire logic                      capture_pin_select,
  input wire logic [`TMCU_CHANNELS-1:0] match_pin
);
  // ----------------------------------------
  // helper terms
  // ----------------------------------------
  logic       acc;
  logic       mapped;
  logic       em_wr;
  logic [3:0] rst_bits;
  logic [3:0] stop_bits;

  // bus decode and per-channel action bits
  assign acc = apb_req.psel && apb_req.penable;
  assign mapped = apb_req.paddr[1:0] == 2'h0 && apb_req.paddr >= `TMCU_OFS_MATCH_VALUE_0
                  && apb_req.paddr <= `TMCU_OFS_IRQ_MASK;
  assign em_wr = acc && apb_rsp.pready && apb_req.pwrite
                 && apb_req.paddr == `TMCU_OFS_EXT_MATCH_CTRL;
  assign rst_bits = {match_action_control[10], match_action_control[7],
                     match_action_control[4], match_action_control[1]};
  assign stop_bits = {match_action_control[11], match_action_control[8],
                      match_action_control[5], match_action_control[2]};

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence wait_s;
    acc && !apb_rsp.pready;
  endsequence
  sequence cap_wr_s;
    acc && apb_rsp.pready && apb_req.pwrite && apb_req.paddr == `TMCU_OFS_CAPTURE_CONTROL;
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  apb_wait_a: assert property (wait_s |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("bus answer not one wait state");
  decode_err_a: assert property (acc && apb_rsp.pready |-> apb_rsp.pslverr == !mapped)
    else $error("error flag disagrees with the map");
  event_once_a: assert property (
    match_event != 4'h0 |=> (match_event & $past(match_event)) == 4'h0)
    else $error("match event held two cycles");
  reset_req_a: assert property (count_reset_req == |(match_event & $past(rst_bits)))
    else $error("count reset request wrong");
  stop_req_a: assert property (count_stop_req == |(match_event & $past(stop_bits)))
    else $error("count stop request wrong");
  pin_cause_a: assert property (
    !$past(em_wr) |-> ((match_pin ^ $past(match_pin)) & ~match_event) == 4'h0)
    else $error("match pin moved without a cause");
  pwm_hold_a: assert property (
    !$past(em_wr) |-> ((match_pin ^ $past(match_pin)) & $past(pwm_mode)) == 4'h0)
    else $error("pwm channel pin moved on a match");
  pin_select_a: assert property (
    cap_wr_s |-> ##2 capture_pin_select == $past(apb_req.pwdata[3], 2))
    else $error("capture pin select does not follow enable");
endmodule : tmcu_monitor
`default_nettype wire

// file: testbench/tmcu_pin_model.sv
// far-side model: source of the capture input signal
`timescale 1ns/1ps
`default_nettype none
module tmcu_pin_model (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // level asked for by the bench
  input  wire logic want_level,
  // capture pin towards the unit
  output logic      capture_input_pin
);
  logic [1:0] held_ff;  // cycles the pin has held its level

  // a new level goes out only after the old one stood two clocks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      capture_input_pin <= 1'b0;
      held_ff <= 2'h0;
    end else if (want_level != capture_input_pin && held_ff != 2'h0) begin
      capture_input_pin <= want_level;
      held_ff <= 2'h0;
    end else if (held_ff != 2'h3) begin
      held_ff <= held_ff + 2'h1;
    end
  end
endmodule : tmcu_pin_model
`default_nettype wire

// file: testbench/timer_match_capture_unit_tb_top.sv
// testbench top of the match/capture unit
`timescale 1ns/1ps
`default_nettype none
`include "tmcu_cfg.svh"
module timer_match_capture_unit_tb_top
  import tmcu_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  tmcu_apb_req_s apb_req = '0;
  tmcu_apb_rsp_s apb_rsp;
  logic [31:0]   timer_count = 32'h0000_0001;
  logic [11:0]   match_action_control = 12'h000;
  logic [3:0]    pwm_mode = 4'h0;
  logic [3:0]    match_event;
  logic [3:0]    match_pin;
  logic          count_reset_req;
  logic          count_stop_req;
  logic          capture_pin_select;
  logic          capture_input_pin;
  logic          irq;
  logic          want_level = 1'b0;
  int            n_fail = 0;
  int            samples_checked = 0;
  int            cycles = 0;

  // clock at 125 MHz
  always #4 clock = ~clock;

  tmcu_top dut (.clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .timer_count(timer_count), .match_action_control(match_action_control),
    .pwm_mode(pwm_mode), .match_event(match_event), .count_reset_req(count_reset_req),
    .count_stop_req(count_stop_req), .capture_input_pin(capture_input_pin),
    .capture_pin_select(capture_pin_select), .match_pin(match_pin), .irq(irq));
  tmcu_pin_model u_pins (.clock(clock), .rst(rst), .want_level(want_level),
    .capture_input_pin(capture_input_pin));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clock);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do @(posedge clock); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask : rd

  // timer count equals v for one cycle
  task automatic fire(input logic [31:0] v);
    @(posedge clock);
    timer_count <= v;
    @(posedge clock);
    timer_count <= 32'h0000_0001;
    @(negedge clock);
  endtask : fire

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reg_test();
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 9; i++) rd(12'h018 + 12'(4 * i), 32'h0);
    for (int i = 0; i < 4; i++) wr(12'h018 + 12'(4 * i), 32'hA5A5_0000 + 32'(i));
    for (int i = 0; i < 4; i++) rd(12'h018 + 12'(4 * i), 32'hA5A5_0000 + 32'(i));
    wr(`TMCU_OFS_CAPTURE_VALUE, 32'hFFFF_FFFF);
    rd(`TMCU_OFS_CAPTURE_VALUE, 32'h0);
    wr(`TMCU_OFS_CAPTURE_CONTROL, 32'hFFFF_FFF0);
    rd(`TMCU_OFS_CAPTURE_CONTROL, 32'h0);
    wr(`TMCU_OFS_EXT_MATCH_CTRL, 32'hFFFF_FFFF);
    rd(`TMCU_OFS_EXT_MATCH_CTRL, 32'h0000_0FFF);
    chk({28'h0, match_pin}, 32'h0000_000F);
    wr(`TMCU_OFS_EXT_MATCH_CTRL, 32'h0);
    apb(1'b0, 12'h040, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
  endtask : reg_test

  task automatic match_test();
    logic [31:0] v;
    wr(`TMCU_OFS_IRQ_MASK, 32'h0000_001F);
    for (int ch = 0; ch < 4; ch++) begin
      for (int code = 0; code < 4; code++) begin
        v = 32'h0000_0100 * 32'(ch + 1) + 32'(code);
        wr(`TMCU_OFS_EXT_MATCH_CTRL, 32'(code) << (4 + 2 * ch) | 32'(code == 1) << ch);
        wr(12'h018 + 12'(4 * ch), v);
        match_action_control <= 12'((1 + 2 * code) << (3 * ch));
        fire(v);
        chk({28'h0, match_event}, 32'h1 << ch);
        chk({31'h0, match_pin[ch]}, 32'(code >= 2));
        chk({30'h0, count_stop_req, count_reset_req}, 32'(code));
        chk({31'h0, irq}, 32'h1);
        if (code == 3) fire(v);
        if (code == 3) chk({31'h0, match_pin[ch]}, 32'h0);
        rd(`TMCU_OFS_IRQ_STATUS, 32'h1 << ch);
        wr(`TMCU_OFS_IRQ_STATUS, 32'h1 << ch);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0);
      end
    end
    // pwm channel ignores its action; masked event keeps irq low
    @(posedge clock);
    pwm_mode <= 4'h1;
    wr(`TMCU_OFS_IRQ_MASK, 32'h0);
    wr(`TMCU_OFS_EXT_MATCH_CTRL, 32'h0000_0020);
    match_action_control <= 12'h001;
    fire(32'h0000_0103);
    chk({31'h0, match_pin[0]}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(`TMCU_OFS_IRQ_STATUS, 32'h1);
    wr(`TMCU_OFS_IRQ_MASK, 32'h0000_001F);
    // the line follows a new mask one edge after the write lands
    repeat (2) @(negedge clock);
    chk({31'h0, irq}, 32'h1);
    wr(`TMCU_OFS_IRQ_STATUS, 32'h1);
  endtask : match_test

  task automatic capture_test();
    logic [3:0]  ctl [4] = '{4'h9, 4'hA, 4'hF, 4'h3};
    logic [31:0] expc;
    expc = 32'h0;
    for (int k = 0; k < 4; k++) begin
      wr(`TMCU_OFS_CAPTURE_CONTROL, 32'(ctl[k]));
      repeat (2) @(negedge clock);
      chk({31'h0, capture_pin_select}, 32'(ctl[k][3]));
      for (int lv = 1; lv >= 0; lv--) begin
        @(posedge clock);
        timer_count <= 32'h0000_A000 + 32'(4 * k + lv);
        want_level <= (lv == 1);
        repeat (8) @(posedge clock);
        if (ctl[k][3] && ctl[k][1 - lv]) expc = 32'h0000_A000 + 32'(4 * k + lv);
        rd(`TMCU_OFS_CAPTURE_VALUE, expc);
      end
      @(negedge clock);
      chk({31'h0, irq}, 32'(ctl[k] == 4'hF));
      wr(`TMCU_OFS_IRQ_STATUS, 32'h0000_0010);
    end
    wr(`TMCU_OFS_CAPTURE_CONTROL, 32'h0);
  endtask : capture_test

  // ----------------------------------------
  // run control
  // ----------------------------------------
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail++;
      complete_run();
    end
  end

  // reset then the scenarios in turn
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    reg_test();
    match_test();
    capture_test();
    complete_run();
  end
endmodule : timer_match_capture_unit_tb_top

bind tmcu_top tmcu_monitor u_mon (.clock(clock), .rst(rst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .match_action_control(match_action_control), .pwm_mode(pwm_mode),
  .match_event(match_event), .count_reset_req(count_reset_req),
  .count_stop_req(count_stop_req), .capture_pin_select(capture_pin_select),
  .match_pin(match_pin));
`default_nettype wire
